/* File: rtl/vdop_consts.vh */
// Constants for the parallel video output port of the link deserializer.
// Included by vdop_output_port.v; holds definitions only.
`ifndef VDOP_CONSTS_VH
`define VDOP_CONSTS_VH

// Widths
`define VDOP_RGB_W        24
`define VDOP_CH_W         8
`define VDOP_AXI_AW       8
`define VDOP_AXI_DW       32
`define VDOP_ADDR_LSB     2
`define VDOP_IN_W         56

// Positions inside the raw input vector
`define VDOP_IN_LCLK      0
`define VDOP_IN_LOCK      1
`define VDOP_IN_PDN       2
`define VDOP_IN_BIST      3
`define VDOP_IN_DE        4
`define VDOP_IN_HS        5
`define VDOP_IN_VS        6
`define VDOP_IN_ERR       7
`define VDOP_IN_RGB       8
`define VDOP_IN_STRAP     32

// Strap positions on the shared colour pins (red 23:16, green 15:8, blue 7:0)
`define VDOP_PIN_B1       1
`define VDOP_PIN_B2       2
`define VDOP_PIN_B4       4
`define VDOP_PIN_B6       6
`define VDOP_PIN_B7       7
`define VDOP_PIN_EQ_LO    12
`define VDOP_PIN_SSC_LO   19
`define VDOP_EQ_W         4
`define VDOP_SSC_W        4

// Register byte offsets
`define VDOP_REG_CTRL     8'h00
`define VDOP_REG_STATUS   8'h04
`define VDOP_REG_STRAP    8'h08
`define VDOP_REG_IRQ_STAT 8'h0c
`define VDOP_REG_IRQ_MASK 8'h10

// Control register fields
`define VDOP_CTRL_OVR     0
`define VDOP_CTRL_MODE_LO 1
`define VDOP_CTRL_EDGE    3
`define VDOP_CTRL_SLEEP   4
`define VDOP_CTRL_EQ_LO   5
`define VDOP_CTRL_LF      9
`define VDOP_CTRL_SSC     10
`define VDOP_CTRL_W       11
`define VDOP_CTRL_RST     11'h000

// Interrupt bits
`define VDOP_IRQ_W        3
`define VDOP_IRQ_LOCK_UP  0
`define VDOP_IRQ_LOCK_DN  1
`define VDOP_IRQ_BIST_ERR 2
`define VDOP_IRQ_RST      3'h0

// Operating mode codes
`define VDOP_MODE_FILT_OFF 2'h0
`define VDOP_MODE_FILT_ON  2'h1
`define VDOP_MODE_LEGACY_A 2'h2
`define VDOP_MODE_LEGACY_B 2'h3

// AXI responses
`define VDOP_RESP_OKAY    2'h0
`define VDOP_RESP_SLVERR  2'h2

// Strap settle time before capture
`define VDOP_CLK_MHZ      125
`define VDOP_STRAP_NS     1000
`define VDOP_STRAP_CYC    ((`VDOP_STRAP_NS * `VDOP_CLK_MHZ + 999) / 1000)
`define VDOP_CNT_W        12

`endif

/* File: rtl/vdop_output_port.v */
// Parallel video output port of a serial-link video deserializer, with
// strap capture, control-signal filter, sleep handling and AXI4-Lite regs.
// Assumes the recovery loop delivers pixel data that changes on the rising
// edge of link_clk_i; everything from the link and the pins is asynchronous.
//
// Behaviour
// [R1] Each colour channel leaves as an 8-bit bus, bit 7 most significant, sleep state when down.
// [R2] Colour pins stay inputs during power-up and drive only after the straps are captured.
// [R3] With filter mode 01, data-enable and line sync pass only pulses of three pixel clocks or more.
// [R4] With filter mode 00, data-enable and line sync are passed with no minimum width.
// [R5] The sender keeps data-enable and line sync to two transitions per 130 pixel clocks.
// [R6] The sender keeps frame sync to one transition per 130 pixel clocks.
// [R7] Lock output is high while locked and running, else outputs take the sleep state.
// [R8] In self-test the pass flag stays high until a payload error is seen, then goes low.
// [R9] The pixel clock leaves with its strobe edge chosen by the edge select, sleeping when down.
// [R10] Straps are sampled at power-up; an undriven strap reads low.
// [R11] The two-bit mode from pins or register picks peer type and filter behaviour.
// [R12] The spread low-frequency setting counts only while spread clocking is enabled.
// [R13] Sleep-state select together with power-down decides every parallel output while asleep.
// [R14] Low-frequency value 1 suits 5 to 20 MHz pixel clocks, value 0 suits 20 to 65 MHz.
// [R15] Colour, sync and data-enable update once per pixel clock, away from the strobe edge.
`timescale 1ns/1ps
`include "vdop_consts.vh"

module vdop_output_port
(
  // Clock, reset, enable
  input  wire                        clk_sys_i,
  input  wire                        resetn_i,
  input  wire                        ce_i,
  // Recovered link side
  input  wire                        link_clk_i,
  input  wire                        link_locked_i,
  input  wire [`VDOP_RGB_W-1:0]      link_rgb_i,
  input  wire                        link_de_i,
  input  wire                        link_hs_i,
  input  wire                        link_vs_i,
  input  wire                        link_err_i,
  // Control pins
  input  wire                        power_down_n_i,
  input  wire                        bist_en_i,
  // Shared colour and strap pins
  input  wire [`VDOP_RGB_W-1:0]      rgb_i,
  output wire [`VDOP_RGB_W-1:0]      rgb_o,
  output wire                        rgb_oe_o,
  // Video control outputs
  output wire                        pixel_valid_out_o,
  output wire                        line_sync_out_o,
  output wire                        frame_sync_out_o,
  output wire                        pclk_o,
  output wire                        ctrl_oe_o,
  // Status and settings to the analog side
  output wire                        lock_o,
  output wire                        pass_o,
  output wire [`VDOP_EQ_W-1:0]       rx_equalization_sel_o,
  output wire                        spread_spectrum_clocking_o,
  output wire                        spread_low_freq_sel_o,
  output wire                        irq_o,
  // AXI4-Lite slave
  input  wire [`VDOP_AXI_AW-1:0]     s_axi_awaddr,
  input  wire                        s_axi_awvalid,
  output wire                        s_axi_awready,
  input  wire [`VDOP_AXI_DW-1:0]     s_axi_wdata,
  input  wire [3:0]                  s_axi_wstrb,
  input  wire                        s_axi_wvalid,
  output wire                        s_axi_wready,
  output wire [1:0]                  s_axi_bresp,
  output wire                        s_axi_bvalid,
  input  wire                        s_axi_bready,
  input  wire [`VDOP_AXI_AW-1:0]     s_axi_araddr,
  input  wire                        s_axi_arvalid,
  output wire                        s_axi_arready,
  output wire [`VDOP_AXI_DW-1:0]     s_axi_rdata,
  output wire [1:0]                  s_axi_rresp,
  output wire                        s_axi_rvalid,
  input  wire                        s_axi_rready
);

  localparam [2:0] ST_PDN   = 3'h1;
  localparam [2:0] ST_STRAP = 3'h2;
  localparam [2:0] ST_RUN   = 3'h4;

  // Two-stage synchroniser for every asynchronous input
  wire [`VDOP_IN_W-1:0] raw_in = {rgb_i, link_rgb_i, link_err_i, link_vs_i, link_hs_i,
                                  link_de_i, bist_en_i, power_down_n_i, link_locked_i,
                                  link_clk_i};
  reg  [`VDOP_IN_W-1:0] sync1_reg;
  reg  [`VDOP_IN_W-1:0] sync2_reg;
  reg                   lclk_q_reg;

  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sync1_reg  <= {`VDOP_IN_W{1'b0}};
      sync2_reg  <= {`VDOP_IN_W{1'b0}};
      lclk_q_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      sync1_reg  <= raw_in;
      sync2_reg  <= sync1_reg;
      lclk_q_reg <= sync2_reg[`VDOP_IN_LCLK];
    end
  end

  wire lclk_s   = sync2_reg[`VDOP_IN_LCLK];
  wire lock_s   = sync2_reg[`VDOP_IN_LOCK];
  wire pdn_s    = sync2_reg[`VDOP_IN_PDN];
  wire bist_s   = sync2_reg[`VDOP_IN_BIST];
  // Sample at the falling link edge, mid-way between data changes
  wire pix_tick = lclk_q_reg & ~lclk_s;
  wire [`VDOP_RGB_W-1:0] rgb_s   = sync2_reg[`VDOP_IN_RGB +: `VDOP_RGB_W];
  wire [`VDOP_RGB_W-1:0] strap_s = sync2_reg[`VDOP_IN_STRAP +: `VDOP_RGB_W];

  // Power-up sequencing and strap capture
  reg [2:0]             state_reg;
  reg [`VDOP_CNT_W-1:0] settle_reg;
  reg [`VDOP_RGB_W-1:0] strap_reg;

  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_reg  <= ST_PDN;
      settle_reg <= {`VDOP_CNT_W{1'b0}};
      strap_reg  <= {`VDOP_RGB_W{1'b0}};
    end
    else if (ce_i)
    begin
      case (state_reg)
        ST_PDN:
        begin
          settle_reg <= {`VDOP_CNT_W{1'b0}};
          if (pdn_s)
            state_reg <= ST_STRAP;
        end
        ST_STRAP:
        begin
          if (!pdn_s)
            state_reg <= ST_PDN;
          else if (settle_reg == `VDOP_STRAP_CYC - 1)
          begin
            strap_reg <= strap_s; // [R10]
            state_reg <= ST_RUN; // [R2]
          end
          else
            settle_reg <= settle_reg + 1'b1;
        end
        ST_RUN:
        begin
          if (!pdn_s)
            state_reg <= ST_PDN;
        end
        default:
          state_reg <= ST_PDN;
      endcase
    end
  end

  // Strap fields; a pulled-down, undriven pin simply reads as zero
  wire [1:0] strap_mode = {strap_reg[`VDOP_PIN_B6], strap_reg[`VDOP_PIN_B7]};
  wire [`VDOP_EQ_W-1:0]  strap_eq  = strap_reg[`VDOP_PIN_EQ_LO +: `VDOP_EQ_W];
  wire [`VDOP_SSC_W-1:0] strap_ssc = strap_reg[`VDOP_PIN_SSC_LO +: `VDOP_SSC_W];
  wire [`VDOP_AXI_DW-1:0] strap_word = {19'h00000, strap_ssc, strap_reg[`VDOP_PIN_B1],
                                        strap_reg[`VDOP_PIN_B2], strap_reg[`VDOP_PIN_B4],
                                        strap_eq, strap_mode};

  // Effective configuration: register override or straps
  reg  [`VDOP_CTRL_W-1:0] ctrl_reg;
  wire ovr = ctrl_reg[`VDOP_CTRL_OVR];
  wire [1:0] mode = ovr ? ctrl_reg[`VDOP_CTRL_MODE_LO +: 2] : strap_mode;           // [R11]
  wire edge_sel  = ovr ? ctrl_reg[`VDOP_CTRL_EDGE] : strap_reg[`VDOP_PIN_B1];
  wire sleep_sel = ovr ? ctrl_reg[`VDOP_CTRL_SLEEP] : strap_reg[`VDOP_PIN_B2];
  wire [`VDOP_EQ_W-1:0] eq_sel = ovr ? ctrl_reg[`VDOP_CTRL_EQ_LO +: `VDOP_EQ_W] : strap_eq;
  wire ssc_en = ovr ? ctrl_reg[`VDOP_CTRL_SSC] : (|strap_ssc);
  wire lf_raw = ovr ? ctrl_reg[`VDOP_CTRL_LF] : strap_reg[`VDOP_PIN_B4];
  // Low-frequency band (1: slow pixel clocks, 0: fast) only with spread on
  wire lf_eff = ssc_en & lf_raw; // [R12] [R14]
  // Legacy peers and mode 00 both pass control signals unfiltered
  wire filt_on = (mode == `VDOP_MODE_FILT_ON); // [R11]

  // Pixel pipeline: two stages for colour and frame sync, three for data-enable and line sync
  reg [`VDOP_RGB_W-1:0] rgb_d1_reg;
  reg [`VDOP_RGB_W-1:0] rgb_d2_reg;
  reg [1:0]             ctl_d0_reg;
  reg [1:0]             ctl_d1_reg;
  reg [1:0]             ctl_d2_reg;
  reg [1:0]             ctl_filt_reg;
  reg                   vs_d1_reg;
  reg                   vs_d2_reg;

  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rgb_d1_reg <= {`VDOP_RGB_W{1'b0}};
      rgb_d2_reg <= {`VDOP_RGB_W{1'b0}};
      ctl_d0_reg <= 2'h0;
      ctl_d1_reg <= 2'h0;
      ctl_d2_reg <= 2'h0;
      vs_d1_reg  <= 1'b0;
      vs_d2_reg  <= 1'b0;
    end
    else if (ce_i && pix_tick)
    begin
      rgb_d1_reg <= rgb_s;
      rgb_d2_reg <= rgb_d1_reg;
      ctl_d0_reg <= {sync2_reg[`VDOP_IN_HS], sync2_reg[`VDOP_IN_DE]};
      ctl_d1_reg <= ctl_d0_reg;
      ctl_d2_reg <= ctl_d1_reg;
      vs_d1_reg  <= sync2_reg[`VDOP_IN_VS];
      vs_d2_reg  <= vs_d1_reg;
    end
  end

  // Glitch filter: a level is taken after three equal pixel samples,
  // so shorter pulses vanish
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_filt
      always @(posedge clk_sys_i or negedge resetn_i)
      begin
        if (!resetn_i)
          ctl_filt_reg[gi] <= 1'b0;
        else if (ce_i && pix_tick &&
                 ctl_d0_reg[gi] == ctl_d1_reg[gi] && ctl_d1_reg[gi] == ctl_d2_reg[gi])
          ctl_filt_reg[gi] <= ctl_d0_reg[gi]; // [R3]
      end
    end
  endgenerate

  // Filter mode delays colour and frame sync by one stage, data-enable and line sync edges by two
  wire [`VDOP_RGB_W-1:0] rgb_sel = filt_on ? rgb_d2_reg : rgb_d1_reg;
  wire [1:0] ctl_sel = filt_on ? ctl_filt_reg : ctl_d1_reg; // [R4]
  wire       vs_sel  = filt_on ? vs_d2_reg : vs_d1_reg;

  // Output stage: active only while running and locked
  wire active = (state_reg == ST_RUN) & lock_s; // [R7]
  reg [`VDOP_RGB_W-1:0] rgb_out_reg;
  reg                   rgb_oe_reg;
  reg                   de_reg;
  reg                   hs_reg;
  reg                   vs_reg;
  reg                   pclk_reg;
  reg                   ctrl_oe_reg;
  reg                   lock_reg;

  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rgb_out_reg <= {`VDOP_RGB_W{1'b0}};
      rgb_oe_reg  <= 1'b0;
      de_reg      <= 1'b0;
      hs_reg      <= 1'b0;
      vs_reg      <= 1'b0;
      pclk_reg    <= 1'b0;
      ctrl_oe_reg <= 1'b0;
      lock_reg    <= 1'b0;
    end
    else if (ce_i)
    begin
      lock_reg <= active; // [R7]
      if (active)
      begin
        // Data moves at the non-strobe edge of the outgoing pixel clock
        pclk_reg    <= edge_sel ? lclk_s : ~lclk_s; // [R9]
        rgb_oe_reg  <= 1'b1;
        ctrl_oe_reg <= 1'b1;
        if (pix_tick)
        begin
          rgb_out_reg <= rgb_sel; // [R1] [R15]
          de_reg      <= ctl_sel[0]; // [R15]
          hs_reg      <= ctl_sel[1];
          vs_reg      <= vs_sel;
        end
      end
      else
      begin
        // Sleep: held low when select is 0, released to tri-state when 1
        rgb_out_reg <= {`VDOP_RGB_W{1'b0}}; // [R13]
        de_reg      <= 1'b0;
        hs_reg      <= 1'b0;
        vs_reg      <= 1'b0;
        pclk_reg    <= 1'b0; // [R9]
        ctrl_oe_reg <= ~sleep_sel; // [R13]
        // Colour pins must stay inputs until the straps are in
        rgb_oe_reg  <= (state_reg == ST_RUN) & ~sleep_sel; // [R2] [R13]
      end
    end
  end

  // Self-test pass flag: sticky low after the first payload error
  reg pass_reg;
  reg bist_q_reg;
  wire bist_err = bist_s & pass_reg & active & pix_tick & sync2_reg[`VDOP_IN_ERR];

  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pass_reg   <= 1'b1;
      bist_q_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      bist_q_reg <= bist_s;
      if (bist_s & ~bist_q_reg)
        pass_reg <= 1'b1; // [R8]
      else if (bist_err)
        pass_reg <= 1'b0; // [R8]
    end
  end

  // Settings to the receiver front end and clock generator
  reg [`VDOP_EQ_W-1:0] eq_reg;
  reg                  ssc_reg;
  reg                  lf_reg;

  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      eq_reg  <= {`VDOP_EQ_W{1'b0}};
      ssc_reg <= 1'b0;
      lf_reg  <= 1'b0;
    end
    else if (ce_i)
    begin
      eq_reg  <= eq_sel;
      ssc_reg <= ssc_en;
      lf_reg  <= lf_eff; // [R12]
    end
  end

  // AXI4-Lite write path: address and data taken in either order
  reg                     awready_reg;
  reg                     wready_reg;
  reg                     bvalid_reg;
  reg [1:0]               bresp_reg;
  reg                     aw_hold_reg;
  reg                     w_hold_reg;
  reg [`VDOP_AXI_AW-1:0]  aw_addr_reg;
  reg [`VDOP_AXI_DW-1:0]  w_data_reg;
  reg [3:0]               w_strb_reg;
  reg [`VDOP_IRQ_W-1:0]   irq_mask_reg;

  wire aw_hs  = s_axi_awvalid & awready_reg;
  wire w_hs   = s_axi_wvalid & wready_reg;
  wire commit = aw_hold_reg & w_hold_reg & ~bvalid_reg;
  wire [`VDOP_AXI_AW-1:0] wa = {aw_addr_reg[`VDOP_AXI_AW-1:`VDOP_ADDR_LSB], 2'h0};
  wire [`VDOP_AXI_DW-1:0] wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                                   {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  wire [`VDOP_AXI_DW-1:0] ctrl_wide = {21'h000000, ctrl_reg};
  wire [`VDOP_AXI_DW-1:0] mask_wide = {29'h00000000, irq_mask_reg};
  wire [`VDOP_AXI_DW-1:0] ctrl_new  = (ctrl_wide & ~wmask) | (w_data_reg & wmask);
  wire [`VDOP_AXI_DW-1:0] mask_new  = (mask_wide & ~wmask) | (w_data_reg & wmask);
  wire wr_ctrl = (wa == `VDOP_REG_CTRL);
  wire wr_mask = (wa == `VDOP_REG_IRQ_MASK);

  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      awready_reg  <= 1'b1;
      wready_reg   <= 1'b1;
      bvalid_reg   <= 1'b0;
      bresp_reg    <= `VDOP_RESP_OKAY;
      aw_hold_reg  <= 1'b0;
      w_hold_reg   <= 1'b0;
      aw_addr_reg  <= {`VDOP_AXI_AW{1'b0}};
      w_data_reg   <= {`VDOP_AXI_DW{1'b0}};
      w_strb_reg   <= 4'h0;
      ctrl_reg     <= `VDOP_CTRL_RST;
      irq_mask_reg <= `VDOP_IRQ_RST;
    end
    else if (ce_i)
    begin
      if (aw_hs)
      begin
        aw_addr_reg <= s_axi_awaddr;
        aw_hold_reg <= 1'b1;
        awready_reg <= 1'b0;
      end
      if (w_hs)
      begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        w_hold_reg <= 1'b1;
        wready_reg <= 1'b0;
      end
      if (commit)
      begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= (wr_ctrl | wr_mask) ? `VDOP_RESP_OKAY : `VDOP_RESP_SLVERR;
        if (wr_ctrl)
          ctrl_reg <= ctrl_new[`VDOP_CTRL_W-1:0];
        if (wr_mask)
          irq_mask_reg <= mask_new[`VDOP_IRQ_W-1:0];
      end
      if (bvalid_reg & s_axi_bready)
      begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  // AXI4-Lite read path; reading the interrupt status clears it
  reg                    arready_reg;
  reg                    rvalid_reg;
  reg [1:0]              rresp_reg;
  reg [`VDOP_AXI_DW-1:0] rdata_reg;
  reg [`VDOP_IRQ_W-1:0]  irq_stat_reg;
  reg [`VDOP_AXI_DW-1:0] rd_mux;
  reg                    rd_ok;

  wire ar_hs = s_axi_arvalid & arready_reg;
  wire [`VDOP_AXI_AW-1:0] ra = {s_axi_araddr[`VDOP_AXI_AW-1:`VDOP_ADDR_LSB], 2'h0};
  wire [`VDOP_AXI_DW-1:0] status_word = {25'h0000000, bist_s, pdn_s, mode,
                                         (state_reg == ST_RUN), pass_reg, lock_reg};

  // Read decode
  always @*
  begin
    rd_mux = {`VDOP_AXI_DW{1'b0}};
    rd_ok  = 1'b1;
    case (ra)
      `VDOP_REG_CTRL:     rd_mux = ctrl_wide;
      `VDOP_REG_STATUS:   rd_mux = status_word;
      `VDOP_REG_STRAP:    rd_mux = strap_word;
      `VDOP_REG_IRQ_STAT: rd_mux = {29'h00000000, irq_stat_reg};
      `VDOP_REG_IRQ_MASK: rd_mux = mask_wide;
      default:            rd_ok  = 1'b0;
    endcase
  end

  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= `VDOP_RESP_OKAY;
      rdata_reg   <= {`VDOP_AXI_DW{1'b0}};
    end
    else if (ce_i)
    begin
      if (ar_hs)
      begin
        arready_reg <= 1'b0;
        rvalid_reg  <= 1'b1;
        rdata_reg   <= rd_mux;
        rresp_reg   <= rd_ok ? `VDOP_RESP_OKAY : `VDOP_RESP_SLVERR;
      end
      else if (rvalid_reg & s_axi_rready)
      begin
        rvalid_reg  <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  // Sticky interrupt status; a new event beats a clearing read
  reg  lock_q_reg;
  reg  irq_reg;
  wire [`VDOP_IRQ_W-1:0] irq_ev  = {bist_err, lock_q_reg & ~active, active & ~lock_q_reg};
  wire [`VDOP_IRQ_W-1:0] irq_clr = {`VDOP_IRQ_W{ar_hs & (ra == `VDOP_REG_IRQ_STAT)}};
  wire [`VDOP_IRQ_W-1:0] irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_ev;

  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      lock_q_reg   <= 1'b0;
      irq_stat_reg <= `VDOP_IRQ_RST;
      irq_reg      <= 1'b0;
    end
    else if (ce_i)
    begin
      lock_q_reg   <= active;
      irq_stat_reg <= irq_stat_next;
      irq_reg      <= |(irq_stat_next & irq_mask_reg);
    end
  end

  // Port drive, all from flip-flops
  assign rgb_o                      = rgb_out_reg;
  assign rgb_oe_o                   = rgb_oe_reg;
  assign pixel_valid_out_o          = de_reg;
  assign line_sync_out_o            = hs_reg;
  assign frame_sync_out_o           = vs_reg;
  assign pclk_o                     = pclk_reg;
  assign ctrl_oe_o                  = ctrl_oe_reg;
  assign lock_o                     = lock_reg;
  assign pass_o                     = pass_reg;
  assign rx_equalization_sel_o      = eq_reg;
  assign spread_spectrum_clocking_o = ssc_reg;
  assign spread_low_freq_sel_o      = lf_reg;
  assign irq_o                      = irq_reg;
  assign s_axi_awready              = awready_reg;
  assign s_axi_wready               = wready_reg;
  assign s_axi_bresp                = bresp_reg;
  assign s_axi_bvalid               = bvalid_reg;
  assign s_axi_arready              = arready_reg;
  assign s_axi_rdata                = rdata_reg;
  assign s_axi_rresp                = rresp_reg;
  assign s_axi_rvalid               = rvalid_reg;

endmodule // vdop_output_port

/* File: sim/testbench.sv */
// Bench of the video output port: AXI4-Lite tasks, link driver, checks.
// Assumes the timing controller model resolves the strap pins.
`timescale 1ns/1ps
module testbench;
  reg clk_sys_i = 1'b0, resetn_i = 1'b0, link_clk_i = 1'b0, link_locked_i = 1'b1;
  reg power_down_n_i = 1'b1, bist_en_i = 1'b0, link_de_i = 1'b0, link_err_i = 1'b0;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  reg [23:0] link_rgb_i = 24'h000000;
  reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg [31:0] s_axi_wdata = 32'h0, d;
  reg [15:0] h;
  reg [1:0] r;
  wire [23:0] rgb_i, rgb_o, cap;
  wire [15:0] hits;
  wire [31:0] s_axi_rdata;
  wire [3:0] eq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rgb_oe_o;
  wire pixel_valid_out_o, pclk_o, ctrl_oe_o, lock_o, pass_o, irq_o, ssc, lf;
  integer errors = 0, n_compared = 0, i;
  // Clocks, the link one ten times slower, its edges on falling system edges
  always #4 clk_sys_i = ~clk_sys_i;
  always #40 link_clk_i = ~link_clk_i;
  vdop_output_port dut (.*, .ce_i(1'b1), .link_hs_i(link_de_i), .link_vs_i(1'b0),
    .line_sync_out_o(), .frame_sync_out_o(), .rx_equalization_sel_o(eq), .s_axi_wstrb(4'hf),
    .spread_spectrum_clocking_o(ssc), .spread_low_freq_sel_o(lf));
  vdop_tcon_model tcon (.rgb_i(rgb_o), .oe_i(rgb_oe_o), .de_i(pixel_valid_out_o),
    .pclk_i(pclk_o), .pins_o(rgb_i), .cap_o(cap), .hits_o(hits));
  task chk(input [31:0] seen, input [31:0] exp);
  begin
    n_compared = n_compared + 1;
    if (seen !== exp)
    begin
      errors = errors + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  end
  endtask
  // Both channels offered together, each dropped when taken
  task wr(input [7:0] a, input [31:0] v);
  begin
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk_sys_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  end
  endtask
  task rd(input [7:0] a, output [31:0] v, output [1:0] rs);
  begin
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk_sys_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    v = s_axi_rdata;
    rs = s_axi_rresp;
  end
  endtask
  task px(input integer n);
  begin
    repeat (n) @(posedge link_clk_i);
    @(posedge clk_sys_i);
  end
  endtask
  // Spacing keeps the sender in its transition budget
  task pulse(input integer n);
  begin
    @(posedge link_clk_i) link_de_i <= 1'b1;
    repeat (n) @(posedge link_clk_i);
    link_de_i <= 1'b0;
    px(140);
    @(posedge clk_sys_i);
  end
  endtask
  task finish_test;
  begin
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    while (!(rgb_oe_o && lock_o)) @(posedge clk_sys_i);
    rd(8'h08, d, r);
    chk(d, 32'h101);
    @(posedge link_clk_i) link_rgb_i <= 24'h81c3e7;
    px(8);
    chk(cap, 24'h81c3e7);
    h = hits;
    pulse(2);
    chk(hits - h, 0);
    h = hits;
    pulse(3);
    chk(hits - h, 3);
    wr(8'h00, 32'h9);
    h = hits;
    pulse(1);
    chk(hits - h, 1);
    for (i = 0; i < 4; i = i + 1)
    begin
      wr(8'h00, 32'h9 | (i << 1));
      rd(8'h04, d, r);
      chk((d >> 3) & 3, i);
    end
    wr(8'h00, 32'h2a9);
    repeat (2) @(posedge clk_sys_i);
    chk({ssc, lf, eq}, 6'h05);
    wr(8'h00, 32'h6a9);
    repeat (2) @(posedge clk_sys_i);
    chk({ssc, lf, eq}, 6'h35);
    wr(8'h10, 32'h2);
    link_locked_i <= 1'b0;
    while (!irq_o) @(posedge clk_sys_i);
    chk(lock_o, 0);
    rd(8'h0c, d, r);
    chk(d & 2, 2);
    repeat (2) @(posedge clk_sys_i);
    chk(irq_o, 0);
    link_locked_i <= 1'b1;
    while (!lock_o) @(posedge clk_sys_i);
    bist_en_i <= 1'b1;
    px(4);
    chk(pass_o, 1);
    @(posedge link_clk_i) link_err_i <= 1'b1;
    @(posedge link_clk_i) link_err_i <= 1'b0;
    px(6);
    chk(pass_o, 0);
    rd(8'h20, d, r);
    chk({d, r}, 34'h2);
    power_down_n_i <= 1'b0;
    while (rgb_oe_o) @(posedge clk_sys_i);
    repeat (4) @(posedge clk_sys_i);
    chk({lock_o, ctrl_oe_o, pixel_valid_out_o, pclk_o, rgb_o}, 28'h4000000);
    finish_test;
  end
  // Watchdog
  initial
  begin
    #700000;
    errors = errors + 1;
    finish_test;
  end
endmodule // testbench

/* File: sim/vdop_checker.sv */
// Checker of the video output port: bus, sleep and test flags.
// Bound to vdop_output_port; sees its ports only.
`timescale 1ns/1ps
`include "vdop_consts.vh"
module vdop_checker
(
  // Clock, reset and pins
  input wire                   clk_sys_i,
  input wire                   resetn_i,
  input wire                   power_down_n_i,
  input wire                   bist_en_i,
  input wire                   link_locked_i,
  input wire [`VDOP_RGB_W-1:0] rgb_o,
  input wire                   rgb_oe_o,
  input wire                   pixel_valid_out_o,
  input wire                   pclk_o,
  input wire                   lock_o,
  input wire                   pass_o,
  // Register bus
  input wire                   s_axi_awvalid,
  input wire                   s_axi_awready,
  input wire                   s_axi_wvalid,
  input wire                   s_axi_wready,
  input wire                   s_axi_bvalid,
  input wire                   s_axi_arvalid,
  input wire                   s_axi_arready,
  input wire                   s_axi_rvalid
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  // Handshake steps of the two bus directions
  sequence s_aw; s_axi_awvalid && s_axi_awready; endsequence
  sequence s_w; s_axi_wvalid && s_axi_wready; endsequence
  sequence s_ar; s_axi_arvalid && s_axi_arready; endsequence
  a_write_answer: assert property (s_aw ##0 s_w |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_read_answer: assert property (s_ar |=> s_axi_rvalid)
    else $error("read answer late");
  // Outputs and lock share one register stage
  a_quiet_unlock: assert property (!lock_o && !$past(lock_o) |-> rgb_o == 0 && !pixel_valid_out_o)
    else $error("outputs active while unlocked");
  a_pins_wait: assert property ($rose(rgb_oe_o) |-> $past(power_down_n_i, 100))
    else $error("colour pins driven before straps settled");
  a_lock_drop: assert property (!link_locked_i [*6] |-> !lock_o)
    else $error("lock held without link lock");
  a_pass_rise: assert property ($rose(pass_o) |-> $past(bist_en_i, 2))
    else $error("pass set without self-test");
  a_pass_fall: assert property ($fell(pass_o) |-> bist_en_i)
    else $error("pass cleared outside self-test");
  a_pclk_data: assert property (lock_o && $past(lock_o) && $changed(rgb_o) |-> $changed(pclk_o))
    else $error("colour changed off the clock edge");
endmodule // vdop_checker

bind vdop_output_port vdop_checker u_chk (.clk_sys_i, .resetn_i, .power_down_n_i, .bist_en_i,
  .link_locked_i, .rgb_o, .rgb_oe_o, .pixel_valid_out_o, .pclk_o, .lock_o, .pass_o,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

/* File: sim/vdop_tcon_model.sv */
// Timing controller model: captures the port on the rising strobe edge.
// Resolves the shared colour pins; undriven pins read the PULLUPS pattern.
`timescale 1ns/1ps
module vdop_tcon_model
#(
  parameter [23:0] PULLUPS = 24'h000082
)
(
  // Port outputs
  input  wire [23:0] rgb_i,
  input  wire        oe_i,
  input  wire        de_i,
  input  wire        pclk_i,
  // Pin level and captures
  output wire [23:0] pins_o,
  output reg  [23:0] cap_o,
  output reg  [15:0] hits_o = 16'h0000
);
  // Released pins read the pull resistors
  assign pins_o = oe_i ? rgb_i : PULLUPS;
  // Rising strobe, so data must already be stable here
  always @(posedge pclk_i)
  begin
    cap_o <= rgb_i;
    hits_o <= hits_o + {15'h0000, de_i};
  end
endmodule // vdop_tcon_model
